// [rtl/dmo_defs.svh]
// constants for the data memory and option map block
`ifndef DMO_DEFS_SVH
`define DMO_DEFS_SVH
`define DMO_SFR_OPTION_INDEX 8'hFE
`define DMO_SFR_OPTION_DATA 8'hFF
`define DMO_SFR_PSW 8'hD0
`define DMO_SFR_SP 8'h81
`define DMO_PSW_BANK_LO_POS 3
`define DMO_PSW_BANK_HI_POS 4
`define DMO_OPTION_INDEX_RESET 8'h00
`define DMO_SP_RESET 8'h07
`define DMO_OPT_CONTROL_0 8'hC1
`define DMO_OPT_HRC_TRIM 8'h83
`define DMO_OPT_REGION_LO 8'h80
`define DMO_OPT_REGION_HI 8'hC1
`define DMO_WDT_ENABLE_POS 7
`define DMO_OPT_CONTROL_0_RESET 8'h00
`define DMO_IRAM_LO_TOP 8'h7F
`define DMO_BIT_AREA_BASE 8'h20
`define DMO_BANK_BASE 8'h00
`define DMO_XRAM_TOP 16'h0EFF
`define DMO_DISP_BASE 16'h0F00
`define DMO_DISP_TOP 16'h0F17
`define DMO_PWM_BASE 16'h0F40
`define DMO_PWM_TOP 16'h0F4F
`define DMO_TRIM_STEP_PPM 1800
`define DMO_HRC_NOMINAL_KHZ 32000
`define DMO_CLK_MAX_KHZ 35200
`endif

// [rtl/dmo_pkg.sv]
// types for the data memory and option map block
package dmo_pkg;
  typedef enum logic [1:0] {
    DMO_SP_DIRECT,
    DMO_SP_INDIRECT,
    DMO_SP_XDATA,
    DMO_SP_BIT
  } dmo_space_e;
  typedef enum logic [2:0] {
    DMO_TGT_NONE,
    DMO_TGT_IRAM,
    DMO_TGT_SFR,
    DMO_TGT_XRAM,
    DMO_TGT_PWM,
    DMO_TGT_DISP
  } dmo_target_e;
  typedef logic [2:0] dmo_div_t;
endpackage

// [rtl/dmo_opt_if.sv]
// option window bus between the decoder and the option register bank
`timescale 1ns/1ps
interface dmo_opt_if;
  logic [7:0] index;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport master (output index, output wr, output wdata, input rdata);
  modport slave (input index, input wr, input wdata, output rdata);
endinterface

// [rtl/dmo_option_bank.sv]
// option register bank: oscillator trim and option control 0
`timescale 1ns/1ps
`include "dmo_defs.svh"
module dmo_option_bank (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic por_in,
  input wire logic [7:0] factory_trim_in,
  dmo_opt_if.slave opt,
  output logic [7:0] hrc_trim_out,
  output logic watchdog_enable_out
);
  import dmo_pkg::*;
  logic [7:0] hrc_trim_q;
  logic [7:0] option_control_0_q;
  logic por_seen_q;

  // trim reloads from factory value at power-on and after every warm reset, which clears por_seen_q
  always_ff @(posedge clk_sys_in) begin
    if (ce_in) begin
      if (por_in || !por_seen_q) begin
        hrc_trim_q <= factory_trim_in;
      end else if (opt.wr && opt.index == `DMO_OPT_HRC_TRIM) begin
        hrc_trim_q <= opt.wdata;
      end
    end
  end

  // first-cycle latch so trim is valid even if power-on strobe is missed
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      por_seen_q <= 1'b0;
    end else if (ce_in) begin
      por_seen_q <= 1'b1;
    end
  end

  // option control 0, bit 7 enables the watchdog
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      option_control_0_q <= `DMO_OPT_CONTROL_0_RESET;
    end else if (ce_in && opt.wr && opt.index == `DMO_OPT_CONTROL_0) begin
      option_control_0_q <= opt.wdata;
    end
  end

  // unimplemented indices read zero, writes to them fall on nothing
  always_comb begin
    unique case (opt.index)
      `DMO_OPT_HRC_TRIM: opt.rdata = hrc_trim_q;
      `DMO_OPT_CONTROL_0: opt.rdata = option_control_0_q;
      default: opt.rdata = 8'h00;
    endcase
  end

  assign hrc_trim_out = hrc_trim_q;
  assign watchdog_enable_out = option_control_0_q[`DMO_WDT_ENABLE_POS];
endmodule

// [rtl/dmo_data_memory.sv]
// data memory decoder with internal ram, xdata rams and option window
`timescale 1ns/1ps
`include "dmo_defs.svh"
module dmo_data_memory #(
  parameter int XRAM_BYTES = 3840,
  parameter int PWM_BYTES = 16,
  parameter int DISP_BYTES = 24,
  parameter int IRAM_BYTES = 256
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic por_in,
  input wire logic [7:0] factory_trim_in,
  input wire logic [2:0] clk_div_sel_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire dmo_pkg::dmo_space_e space_in,
  input wire logic [15:0] addr_in,
  input wire logic [2:0] reg_num_in,
  input wire logic use_reg_in,
  input wire logic [7:0] wdata_in,
  input wire logic bit_wdata_in,
  output logic [7:0] rdata_out,
  output logic bit_rdata_out,
  output logic sfr_hit_out,
  output logic unmapped_out,
  output logic [7:0] stack_ptr_out,
  output logic [7:0] hrc_trim_out,
  output logic [2:0] clk_div_out,
  output logic watchdog_enable_out,
  output logic [7:0] pwm_duty_out [16],
  output logic [7:0] disp_ram_out [24]
);
  import dmo_pkg::*;
  // storage is plain flip-flops indexed by address; the xdata array is large, so expect a big register file
  logic [7:0] iram_q [IRAM_BYTES];
  logic [7:0] xram_q [XRAM_BYTES];
  logic [7:0] pwm_q [PWM_BYTES];
  logic [7:0] disp_q [DISP_BYTES];
  logic [7:0] option_index_q;
  logic [7:0] psw_q;
  logic [7:0] sp_q;
  logic [7:0] rdata_q;
  logic bit_rdata_q;
  logic [2:0] clk_div_q;
  // decode results, all combinational from the current request
  dmo_target_e tgt;
  logic [7:0] ia;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic [7:0] opt_rdata;
  logic [1:0] bank;
  logic sfr_wr;
  // carrier for the option window between this decoder and the option bank
  dmo_opt_if opt ();

  // bank register window: r0..r7 of the active bank
  function automatic logic [7:0] bank_addr(input logic [1:0] b, input logic [2:0] r);
    bank_addr = `DMO_BANK_BASE + {3'h0, b, r};
  endfunction

  // the active bank follows the two select bits of the status word
  assign bank = {psw_q[`DMO_PSW_BANK_HI_POS], psw_q[`DMO_PSW_BANK_LO_POS]};

  // address decode by access space
  always_comb begin
    // register operands name r0..r7 of the active bank, so they never reach the special registers
    ia = use_reg_in ? bank_addr(bank, reg_num_in) : addr_in[7:0];
    // bit addresses below 80h live in bytes 20h..2Fh, eight bits per byte
    bit_byte = `DMO_BIT_AREA_BASE + {4'h0, addr_in[6:3]};
    bit_pos = addr_in[2:0];
    tgt = DMO_TGT_NONE;
    unique case (space_in)
      DMO_SP_DIRECT: tgt = (!use_reg_in && ia > `DMO_IRAM_LO_TOP) ? DMO_TGT_SFR : DMO_TGT_IRAM;
      DMO_SP_INDIRECT: tgt = DMO_TGT_IRAM;
      DMO_SP_BIT: tgt = addr_in[7] ? DMO_TGT_SFR : DMO_TGT_IRAM;
      DMO_SP_XDATA: begin
        // the hole between display and pwm ram and all above stay unmapped and read zero
        if (addr_in <= `DMO_XRAM_TOP) begin
          tgt = DMO_TGT_XRAM;
        end else if (addr_in >= `DMO_DISP_BASE && addr_in <= `DMO_DISP_TOP) begin
          tgt = DMO_TGT_DISP;
        end else if (addr_in >= `DMO_PWM_BASE && addr_in <= `DMO_PWM_TOP) begin
          tgt = DMO_TGT_PWM;
        end
      end
    endcase
  end

  // one qualified special-register write strobe, shared by the option window and the local registers
  assign sfr_wr = ce_in && req_in && we_in && tgt == DMO_TGT_SFR && space_in == DMO_SP_DIRECT;

  // option window: index register drives the bank, data port writes through
  assign opt.index = option_index_q;
  assign opt.wdata = wdata_in;
  // writes outside the option region are dropped here, so the bank never sees them
  assign opt.wr = sfr_wr && ia == `DMO_SFR_OPTION_DATA && option_index_q >= `DMO_OPT_REGION_LO &&
    option_index_q <= `DMO_OPT_REGION_HI;
  assign opt_rdata = opt.rdata;

  // the option bank holds trim and control 0; index writes stay local to this module
  dmo_option_bank u_opt (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .por_in(por_in),
    .factory_trim_in(factory_trim_in),
    .opt(opt),
    .hrc_trim_out(hrc_trim_out),
    .watchdog_enable_out(watchdog_enable_out)
  );

  // special registers owned here: option index, psw, stack pointer
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      option_index_q <= `DMO_OPTION_INDEX_RESET;
      psw_q <= 8'h00;
      sp_q <= `DMO_SP_RESET;
    end else if (sfr_wr) begin
      // a new index is seen by the very next data access, no settling cycle needed
      if (ia == `DMO_SFR_OPTION_INDEX) option_index_q <= wdata_in;
      if (ia == `DMO_SFR_PSW) psw_q <= wdata_in;
      if (ia == `DMO_SFR_SP) sp_q <= wdata_in;
    end
  end

  // clock divider select: 0..3 picks /1 /2 /4 /8 of the trimmed oscillator
  // the divider itself sits with the oscillator; only the selection is held here
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      clk_div_q <= 3'h0;
    end else if (ce_in) begin
      clk_div_q <= (clk_div_sel_in > 3'h3) ? 3'h3 : clk_div_sel_in;
    end
  end

  // internal ram writes, byte or single bit in the bit area
  always_ff @(posedge clk_sys_in) begin
    if (ce_in && req_in && we_in && tgt == DMO_TGT_IRAM) begin
      // a bit write touches one flip-flop only, so its neighbours in the byte are safe
      if (space_in == DMO_SP_BIT) begin
        iram_q[bit_byte][bit_pos] <= bit_wdata_in;
      end else begin
        iram_q[ia] <= wdata_in;
      end
    end
  end

  // external-class ram writes, array sizes keep each region honest
  always_ff @(posedge clk_sys_in) begin
    if (ce_in && req_in && we_in) begin
      if (tgt == DMO_TGT_XRAM) xram_q[addr_in[11:0]] <= wdata_in;
      if (tgt == DMO_TGT_PWM) pwm_q[addr_in[3:0]] <= wdata_in;
      if (tgt == DMO_TGT_DISP) disp_q[addr_in[4:0]] <= wdata_in;
    end
  end

  // registered read data; sfr addresses not owned here read zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
      bit_rdata_q <= 1'b0;
    end else if (ce_in && req_in && !we_in) begin
      // a bit read also returns the byte at the raw address; the core uses only the bit
      bit_rdata_q <= (tgt == DMO_TGT_IRAM) ? iram_q[bit_byte][bit_pos] : 1'b0;
      unique case (tgt)
        DMO_TGT_IRAM: rdata_q <= iram_q[ia];
        DMO_TGT_XRAM: rdata_q <= xram_q[addr_in[11:0]];
        DMO_TGT_PWM: rdata_q <= pwm_q[addr_in[3:0]];
        DMO_TGT_DISP: rdata_q <= disp_q[addr_in[4:0]];
        DMO_TGT_SFR: begin
          // only the registers owned here answer; the core routes the rest
          if (ia == `DMO_SFR_OPTION_INDEX) rdata_q <= option_index_q;
          else if (ia == `DMO_SFR_OPTION_DATA) rdata_q <= opt_rdata;
          else if (ia == `DMO_SFR_PSW) rdata_q <= psw_q;
          else if (ia == `DMO_SFR_SP) rdata_q <= sp_q;
          else rdata_q <= 8'h00;
        end
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // exported ram images for the pwm and display consumers
  // consumers see a write one cycle after it is taken, same as a read would
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pwm
      assign pwm_duty_out[g] = pwm_q[g];
    end
    for (g = 0; g < 24; g++) begin : g_disp
      assign disp_ram_out[g] = disp_q[g];
    end
  endgenerate

  // decode flags stay combinational so the core can steer in the same cycle
  assign rdata_out = rdata_q;
  assign bit_rdata_out = bit_rdata_q;
  assign sfr_hit_out = req_in && tgt == DMO_TGT_SFR; // core routes other special registers itself
  assign unmapped_out = req_in && tgt == DMO_TGT_NONE;
  assign stack_ptr_out = sp_q;
  assign clk_div_out = clk_div_q;
endmodule

// [sim/dmo_chk.sv]
// port checker for the data memory decoder
`timescale 1ns/1ps
module dmo_chk (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic por_in,
  input wire logic [7:0] factory_trim_in,
  input wire logic [2:0] clk_div_sel_in,
  input wire logic req_in,
  input wire logic use_reg_in,
  input wire dmo_pkg::dmo_space_e space_in,
  input wire logic [15:0] addr_in,
  input wire logic sfr_hit_out,
  input wire logic unmapped_out,
  input wire logic [7:0] stack_ptr_out,
  input wire logic [7:0] hrc_trim_out,
  input wire logic [2:0] clk_div_out
);
  import dmo_pkg::*;
  // single clock domain
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_direct_hi_sfr: assert property (req_in && !use_reg_in && space_in == DMO_SP_DIRECT && addr_in[7]
    |-> sfr_hit_out)
    else $error("direct upper access missed sfr");
  a_direct_lo_ram: assert property (req_in && space_in == DMO_SP_DIRECT && !addr_in[7] |-> !sfr_hit_out)
    else $error("direct lower access hit sfr");
  a_indirect_ram: assert property (req_in && space_in == DMO_SP_INDIRECT |-> !sfr_hit_out)
    else $error("indirect access hit sfr");
  a_xram_mapped: assert property (req_in && space_in == DMO_SP_XDATA && addr_in <= 16'h0EFF |-> !unmapped_out)
    else $error("xdata ram flagged unmapped");
  a_xdata_gap: assert property (req_in && space_in == DMO_SP_XDATA && addr_in inside {[16'h0F18:16'h0F3F]}
    |-> unmapped_out)
    else $error("xdata gap not unmapped");
  a_por_reload: assert property (ce_in && por_in |=> hrc_trim_out == $past(factory_trim_in))
    else $error("trim not reloaded on power-on");
  a_sp_reset: assert property (disable iff (1'b0) rst_in && ce_in |=> stack_ptr_out == 8'h07)
    else $error("stack pointer reset wrong");
  // selections above divide by 8 must clamp, never wrap
  a_div_clamp: assert property (ce_in && clk_div_sel_in > 3'h3 |=> clk_div_out == 3'h3)
    else $error("clock divider not clamped");
  c_por: cover property (ce_in && por_in);
  c_gap: cover property (req_in && unmapped_out);
  c_sfr: cover property (req_in && sfr_hit_out);
endmodule
bind dmo_data_memory dmo_chk u_dmo_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
  .por_in(por_in), .factory_trim_in(factory_trim_in), .clk_div_sel_in(clk_div_sel_in), .req_in(req_in),
  .use_reg_in(use_reg_in), .space_in(space_in), .addr_in(addr_in), .sfr_hit_out(sfr_hit_out),
  .unmapped_out(unmapped_out), .stack_ptr_out(stack_ptr_out), .hrc_trim_out(hrc_trim_out),
  .clk_div_out(clk_div_out));

// [sim/dmo_core_model.sv]
// processor core model issuing one data memory access at a time
`timescale 1ns/1ps
module dmo_core_model (
  input wire logic clk_sys_in,
  input wire logic [7:0] rdata_in,
  input wire logic bit_rdata_in,
  output logic req_out,
  output logic we_out,
  output dmo_pkg::dmo_space_e space_out,
  output logic [15:0] addr_out,
  output logic [3:0] reg_out,
  output logic [7:0] wdata_out
);
  import dmo_pkg::*;
  logic [7:0] rd = 8'h00;
  logic rb = 1'b0;
  initial begin
    req_out = 1'b0;
    we_out = 1'b0;
    space_out = DMO_SP_DIRECT;
    addr_out = 16'h0000;
    reg_out = 4'h0;
    wdata_out = 8'h00;
  end
  // launched after a falling edge, taken at the next rising one; idle lines toggle so stale data never matches
  task automatic acc(input dmo_space_e s, input logic w, input logic [15:0] a, input logic [7:0] d,
    input logic [3:0] r);
    if (s == DMO_SP_DIRECT && w && a == 16'h00FE && (d < 8'h80 || d > 8'hC1)) return;
    @(negedge clk_sys_in);
    req_out = 1'b1;
    we_out = w;
    space_out = s;
    addr_out = a;
    reg_out = r;
    wdata_out = d;
    @(negedge clk_sys_in);
    rd = rdata_in;
    rb = bit_rdata_in;
    {req_out, addr_out, wdata_out} = {1'b0, ~addr_out, ~wdata_out};
  endtask
  // option bit set by index write then read-modify-write of the data window
  task automatic rmw_or(input logic [7:0] idx, input logic [7:0] m);
    acc(DMO_SP_DIRECT, 1'b1, 16'h00FE, idx, 4'h0);
    acc(DMO_SP_DIRECT, 1'b0, 16'h00FF, 8'h00, 4'h0);
    acc(DMO_SP_DIRECT, 1'b1, 16'h00FF, rd | m, 4'h0);
  endtask
endmodule

// [sim/test_dmo_data_memory.sv]
// self-checking bench for the data memory decoder
`timescale 1ns/1ps
module test_dmo_data_memory;
  import dmo_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic por_in = 1'b0;
  logic [7:0] fac = 8'h5A;
  logic [2:0] sel = 3'h0;
  logic req, we, sfr, unm, wdog, brd;
  dmo_space_e sp_e;
  logic [15:0] addr;
  logic [3:0] rg;
  logic [7:0] wd, rdat, sp, trim;
  logic [2:0] div;
  logic [7:0] pwm [16];
  logic [7:0] disp [24];
  int err_count = 0;
  int checked = 0;
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  dmo_data_memory u_dmo_data_memory (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1), .por_in(por_in),
    .factory_trim_in(fac), .clk_div_sel_in(sel), .req_in(req), .we_in(we), .space_in(sp_e), .addr_in(addr),
    .reg_num_in(rg[2:0]), .use_reg_in(rg[3]), .wdata_in(wd), .bit_wdata_in(wd[0]), .rdata_out(rdat),
    .bit_rdata_out(brd), .sfr_hit_out(sfr), .unmapped_out(unm), .stack_ptr_out(sp), .hrc_trim_out(trim),
    .clk_div_out(div), .watchdog_enable_out(wdog), .pwm_duty_out(pwm), .disp_ram_out(disp));
  dmo_core_model u_dmo_core_model (.clk_sys_in(clk_sys_in), .rdata_in(rdat), .bit_rdata_in(brd), .req_out(req),
    .we_out(we), .space_out(sp_e), .addr_out(addr), .reg_out(rg), .wdata_out(wd));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input dmo_space_e s, input logic [15:0] a, input logic [7:0] d, input logic [3:0] r = 4'h0);
    u_dmo_core_model.acc(s, 1'b1, a, d, r);
  endtask
  task automatic rd(input dmo_space_e s, input logic [15:0] a, input logic [7:0] e, input string n);
    u_dmo_core_model.acc(s, 1'b0, a, 8'h00, 4'h0);
    chk(n, u_dmo_core_model.rd, e);
  endtask
  // option window: index, trim and watchdog bit, with neighbours left alone
  task automatic t_option;
    rd(DMO_SP_DIRECT, 16'h00FE, 8'h00, "index");
    wr(DMO_SP_DIRECT, 16'h00FE, 8'h83);
    rd(DMO_SP_DIRECT, 16'h00FF, 8'h5A, "trim read");
    wr(DMO_SP_DIRECT, 16'h00FF, 8'h5B);
    chk("trim", trim, 8'h5B);
    wr(DMO_SP_DIRECT, 16'h00FE, 8'h80);
    wr(DMO_SP_DIRECT, 16'h00FF, 8'hA5);
    rd(DMO_SP_DIRECT, 16'h00FF, 8'h00, "empty option");
    u_dmo_core_model.rmw_or(8'hC1, 8'h80);
    chk("watchdog", {7'h00, wdog}, 8'h01);
    chk("trim kept", trim, 8'h5B);
    rd(DMO_SP_DIRECT, 16'h00FE, 8'hC1, "index");
  endtask
  // upper ram only through indirect, stack pointer as a register
  task automatic t_iram;
    wr(DMO_SP_INDIRECT, 16'h0085, 8'h3C);
    wr(DMO_SP_DIRECT, 16'h007F, 8'hC3);
    rd(DMO_SP_INDIRECT, 16'h0085, 8'h3C, "upper ram");
    rd(DMO_SP_INDIRECT, 16'h007F, 8'hC3, "lower ram");
    rd(DMO_SP_DIRECT, 16'h0081, 8'h07, "stack");
    wr(DMO_SP_DIRECT, 16'h0081, 8'h30);
    chk("stack", sp, 8'h30);
  endtask
  // register r2 of every bank, then bit area both ways
  task automatic t_bank_bit;
    for (int b = 0; b < 4; b++) begin
      wr(DMO_SP_DIRECT, 16'h00D0, 8'(b * 8));
      wr(DMO_SP_DIRECT, 16'h0000, 8'(8'h70 + b), 4'hA);
      rd(DMO_SP_INDIRECT, 16'(b * 8 + 2), 8'(8'h70 + b), "bank");
    end
    wr(DMO_SP_INDIRECT, 16'h002F, 8'h00);
    wr(DMO_SP_BIT, 16'h007F, 8'h01);
    rd(DMO_SP_INDIRECT, 16'h002F, 8'h80, "bit set");
    wr(DMO_SP_INDIRECT, 16'h0020, 8'h80);
    wr(DMO_SP_DIRECT, 16'h0007, 8'h00);
    rd(DMO_SP_BIT, 16'h0007, 8'h00, "bit rd");
    chk("bit", {7'h00, u_dmo_core_model.rb}, 8'h01);
  endtask
  // xdata edges of each region and the hole between them
  task automatic t_xdata;
    logic [15:0] a [6] = '{16'h0000, 16'h0EFF, 16'h0F00, 16'h0F17, 16'h0F40, 16'h0F4F};
    foreach (a[i]) wr(DMO_SP_XDATA, a[i], 8'(8'h11 * (i + 1)));
    foreach (a[i]) rd(DMO_SP_XDATA, a[i], 8'(8'h11 * (i + 1)), "xdata");
    chk("disp", disp[23], 8'h44);
    chk("pwm", pwm[15], 8'h66);
    rd(DMO_SP_XDATA, 16'h0F18, 8'h00, "hole");
  endtask
  // divider selections including clamped ones, then a power-on reload
  task automatic t_clock;
    for (int s = 0; s < 8; s++) begin
      sel = 3'(s);
      @(negedge clk_sys_in);
      chk("div", {5'h00, div}, (s > 3) ? 8'h03 : 8'(s));
    end
    fac = 8'h66;
    por_in = 1'b1;
    @(negedge clk_sys_in);
    por_in = 1'b0;
    chk("por trim", trim, 8'h66);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys_in);
    rst_in = 1'b0;
    t_option;
    t_iram;
    t_bank_bit;
    t_xdata;
    t_clock;
    results;
  end
  // about 110 cycles are needed; cut off well beyond
  initial begin
    #50000;
    err_count++;
    results;
  end
endmodule
